// ===== verilog/iru_consts.vh
// Constants for the interrupt response unit
`ifndef IRU_CONSTS_VH
`define IRU_CONSTS_VH

// ====================================================================
// Register offsets (byte addresses)
`define IRU_OFF_CTRL 8'h00
`define IRU_OFF_VBASE 8'h04
`define IRU_OFF_PC 8'h08
`define IRU_OFF_SP 8'h0C
`define IRU_OFF_STATUS 8'h10

// ====================================================================
// Control and status fields
`define IRU_CTRL_MODE_LSB 0
`define IRU_CTRL_EI_BIT 4
`define IRU_CTRL_DI_BIT 5
`define IRU_CTRL_RETN_BIT 6
`define IRU_CTRL_IFF_BIT 8
`define IRU_CTRL_SHADOW_BIT 9
`define IRU_CTRL_BUSY_BIT 10
`define IRU_STAT_FOREIGN_BIT 3

// ====================================================================
// Reset values, vectors, call opcode and response codes
`define IRU_RST_MODE 2'h0
`define IRU_RST_VBASE 8'h00
`define IRU_RST_PC 16'h0000
`define IRU_RST_SP 16'hFFFF
`define IRU_NMI_VECTOR 16'h0066
`define IRU_MODE1_VECTOR 16'h0038
`define IRU_OP_CALL 8'hCD
`define IRU_RESP_OKAY 2'h0
`define IRU_RESP_SLVERR 2'h2

// ====================================================================
// Timing in T-states, and aclk cycles per T-state
`define IRU_T_ACK_INT 4'h7
`define IRU_T_ACK_NMI 4'h5
`define IRU_T_BYTE 4'h3
`define IRU_TSTATE_DIV 4'h4

`endif

// ===== verilog/iru_sync.v
// Two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module iru_sync
#(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
)
(
    input wire aclk,
    input wire aresetn,
    input wire [WIDTH-1:0] din,
    output wire [WIDTH-1:0] dout
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1)
        begin : g_bit
            reg meta;
            reg stable;
            always @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    meta <= INIT[i];
                    stable <= INIT[i];
                end
                else
                begin
                    meta <= din[i];
                    stable <= meta;
                end
            end
            assign dout[i] = stable;
        end
    endgenerate
endmodule

// ===== verilog/iru_tick.v
// T-state enable pulse divider
`timescale 1ns/100ps
`include "iru_consts.vh"
module iru_tick
(
    input wire aclk,
    input wire aresetn,
    output reg tick
);
    reg [3:0] cnt;
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt <= 4'h0;
            tick <= 1'b0;
        end
        else if (cnt == `IRU_TSTATE_DIV - 4'h1)
        begin
            cnt <= 4'h0;
            tick <= 1'b1;
        end
        else
        begin
            cnt <= cnt + 4'h1;
            tick <= 1'b0;
        end
    end
endmodule

// ===== verilog/iru_top.v
// Interrupt response unit with AXI4-Lite registers
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "iru_consts.vh"
module iru_top
(
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire nmi_n,
    input wire int_n,
    input wire [7:0] ack_data,
    input wire [7:0] mem_rdata,
    output reg [15:0] mem_addr,
    output reg [7:0] mem_wdata,
    output reg mem_rd,
    output reg mem_wr,
    output reg int_ack,
    output reg busy,
    output reg irq_enable_out
);
    // ================================================================
    // States
    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_ACK = 3'd1;
    localparam [2:0] ST_OPL = 3'd2;
    localparam [2:0] ST_OPH = 3'd3;
    localparam [2:0] ST_PSH = 3'd4;
    localparam [2:0] ST_PSL = 3'd5;
    localparam [2:0] ST_TBL = 3'd6;
    localparam [2:0] ST_TBH = 3'd7;
    localparam [1:0] CAUSE_NONE = 2'd0;
    localparam [1:0] CAUSE_NMI = 2'd1;
    localparam [1:0] CAUSE_INT = 2'd2;

    // ================================================================
    // Pin synchronisers and T-state enable
    wire [9:0] pins_s;
    wire nmi_s;
    wire int_s;
    wire [7:0] ack_s;
    wire tick;

    iru_sync #(.WIDTH(10), .INIT(10'h3FF)) u_sync
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .din({nmi_n, int_n, ack_data}),
        .dout(pins_s)
    );
    assign nmi_s = pins_s[9];
    assign int_s = pins_s[8];
    assign ack_s = pins_s[7:0];

    iru_tick u_tick
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick)
    );

    // ================================================================
    // State
    reg [2:0] state;
    reg [3:0] tcnt;
    reg [1:0] mode;
    reg [7:0] vbase;
    reg [15:0] pc;
    reg [15:0] sp;
    reg irq_enable_flag;
    reg irq_enable_shadow;
    reg [1:0] cause;
    reg [7:0] vec;
    reg [7:0] opcode;
    reg foreign;
    reg [15:0] target;
    reg [15:0] tbl_ptr;
    reg nmi_q;
    reg nmi_pend;

    wire nmi_fall = nmi_q & ~nmi_s;
    reg [3:0] phase_len;
    wire last_t = tick && (tcnt == phase_len - 4'h1);
    wire is_rst_op = (ack_s[7:6] == 2'b11) && (ack_s[2:0] == 3'b111);

    // two wait states on maskable acknowledge
    always @*
    begin
        case (state)
            ST_ACK: phase_len = (cause == CAUSE_NMI) ? `IRU_T_ACK_NMI : `IRU_T_ACK_INT;
            default: phase_len = `IRU_T_BYTE;
        endcase
    end

    // ================================================================
    // AXI write acceptance and byte-lane merge
    wire wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
    wire [7:0] wa = {s_axi_awaddr[7:2], 2'b00};

    function [31:0] wmerge;
        input [31:0] old;
        input [31:0] d;
        input [3:0] s;
        integer i;
        begin
            for (i = 0; i < 4; i = i + 1)
                wmerge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction

    wire [31:0] ctrl_new = wmerge(32'h0000_0000, s_axi_wdata, s_axi_wstrb);
    wire [31:0] vb_new = wmerge({24'h000000, vbase}, s_axi_wdata, s_axi_wstrb);
    wire [31:0] pc_new = wmerge({16'h0000, pc}, s_axi_wdata, s_axi_wstrb);
    wire [31:0] sp_new = wmerge({16'h0000, sp}, s_axi_wdata, s_axi_wstrb);
    wire wr_map = (wa == `IRU_OFF_CTRL) || (wa == `IRU_OFF_VBASE) || (wa == `IRU_OFF_PC) ||
                  (wa == `IRU_OFF_SP) || (wa == `IRU_OFF_STATUS);
    wire sw_ctrl = wr_go && (wa == `IRU_OFF_CTRL);
    wire idle = (state == ST_IDLE);

    // ================================================================
    // Main sequencer and register file
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state <= ST_IDLE;
            tcnt <= 4'h0;
            mode <= `IRU_RST_MODE;
            vbase <= `IRU_RST_VBASE;
            pc <= `IRU_RST_PC;
            sp <= `IRU_RST_SP;
            irq_enable_flag <= 1'b0;
            irq_enable_shadow <= 1'b0;
            cause <= CAUSE_NONE;
            vec <= 8'h00;
            opcode <= 8'h00;
            foreign <= 1'b0;
            target <= 16'h0000;
            tbl_ptr <= 16'h0000;
            nmi_q <= 1'b1;
            nmi_pend <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `IRU_RESP_OKAY;
        end
        else
        begin
            nmi_q <= nmi_s;
            s_axi_awready <= wr_go;
            s_axi_wready <= wr_go;
            if (wr_go)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_map ? `IRU_RESP_OKAY : `IRU_RESP_SLVERR;
            end
            else if (s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end

            // Software writes; hardware updates below override in the same cycle
            if (sw_ctrl)
            begin
                // mode select; code three is not a mode and is ignored
                if (s_axi_wstrb[0] && ctrl_new[1:0] != 2'b11)
                    mode <= ctrl_new[1:0];
                if (ctrl_new[`IRU_CTRL_EI_BIT])
                begin
                    irq_enable_flag <= 1'b1;
                    irq_enable_shadow <= 1'b1;
                end
                else if (ctrl_new[`IRU_CTRL_DI_BIT])
                begin
                    irq_enable_flag <= 1'b0;
                    irq_enable_shadow <= 1'b0;
                end
                else if (ctrl_new[`IRU_CTRL_RETN_BIT])
                    irq_enable_flag <= irq_enable_shadow;
            end
            if (wr_go && wa == `IRU_OFF_VBASE)
                vbase <= vb_new[7:0];
            // Stack and counter are only writable while idle
            if (wr_go && wa == `IRU_OFF_PC && idle)
                pc <= pc_new[15:0];
            if (wr_go && wa == `IRU_OFF_SP && idle)
                sp <= sp_new[15:0];
            if (wr_go && wa == `IRU_OFF_STATUS && s_axi_wdata[`IRU_STAT_FOREIGN_BIT])
                foreign <= 1'b0;

            // Pending edge: a new edge wins over the accept-clear
            if (nmi_fall)
                nmi_pend <= 1'b1;

            if (tick && !idle)
                tcnt <= last_t ? 4'h0 : tcnt + 4'h1;

            case (state)
                ST_IDLE:
                begin
                    tcnt <= 4'h0;
                    if (tick && (nmi_pend || nmi_fall))
                    begin
                        // always accepted; an edge on this tick is taken at once
                        nmi_pend <= nmi_pend && nmi_fall;
                        cause <= CAUSE_NMI;
                        irq_enable_flag <= 1'b0;
                        state <= ST_ACK;
                    end
                    else if (tick && !int_s && irq_enable_flag)
                    begin
                        cause <= CAUSE_INT;
                        irq_enable_flag <= 1'b0;
                        irq_enable_shadow <= 1'b0;
                        state <= ST_ACK;
                    end
                end
                ST_ACK:
                begin
                    if (last_t)
                    begin
                        if (cause == CAUSE_NMI)
                        begin
                            // fetched byte discarded, restart to 0066H
                            target <= `IRU_NMI_VECTOR;
                            state <= ST_PSH;
                        end
                        else
                        begin
                            case (mode)
                                2'd1:
                                begin
                                    target <= `IRU_MODE1_VECTOR;
                                    state <= ST_PSH;
                                end
                                2'd2:
                                begin
                                    vec <= ack_s;
                                    // low bit taken as the peripheral gives it
                                    tbl_ptr <= {vbase, ack_s};
                                    state <= ST_PSH;
                                end
                                default:
                                begin
                                    opcode <= ack_s;
                                    if (is_rst_op)
                                    begin
                                        target <= {10'h000, ack_s[5:3], 3'b000};
                                        state <= ST_PSH;
                                    end
                                    else if (ack_s == `IRU_OP_CALL)
                                        state <= ST_OPL;
                                    else
                                    begin
                                        // Other opcodes go back to the core
                                        foreign <= 1'b1;
                                        state <= ST_IDLE;
                                    end
                                end
                            endcase
                        end
                    end
                end
                ST_OPL:
                begin
                    if (last_t)
                    begin
                        target[7:0] <= ack_s;
                        state <= ST_OPH;
                    end
                end
                ST_OPH:
                begin
                    if (last_t)
                    begin
                        target[15:8] <= ack_s;
                        state <= ST_PSH;
                    end
                end
                ST_PSH:
                begin
                    if (last_t)
                    begin
                        sp <= sp - 16'h0001;
                        state <= ST_PSL;
                    end
                end
                ST_PSL:
                begin
                    if (last_t)
                    begin
                        sp <= sp - 16'h0001;
                        // table read follows the push in mode two
                        if (cause == CAUSE_INT && mode == 2'd2)
                            state <= ST_TBL;
                        else
                        begin
                            // maskable restart ends after seven plus six, non-maskable restart after five plus six
                            pc <= target;
                            state <= ST_IDLE;
                        end
                    end
                end
                ST_TBL:
                begin
                    // lower address is the low half
                    if (last_t)
                    begin
                        target[7:0] <= mem_rdata;
                        state <= ST_TBH;
                    end
                end
                default:
                begin
                    if (last_t)
                    begin
                        pc <= {mem_rdata, target[7:0]};
                        state <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ================================================================
    // Memory and acknowledge strobes, registered
    reg [15:0] next_mem_addr;
    reg [7:0] next_mem_wdata;
    reg next_mem_rd;
    reg next_mem_wr;
    reg next_int_ack;

    always @*
    begin
        next_mem_addr = 16'h0000;
        next_mem_wdata = 8'h00;
        next_mem_rd = 1'b0;
        next_mem_wr = 1'b0;
        next_int_ack = 1'b0;
        case (state)
            ST_ACK:
            begin
                // Non-maskable path is a real fetch whose byte is dropped
                next_mem_addr = pc;
                next_mem_rd = (cause == CAUSE_NMI);
                next_int_ack = (cause == CAUSE_INT);
            end
            ST_OPL, ST_OPH:
                next_int_ack = 1'b1;
            ST_PSH, ST_PSL:
            begin
                // store below the current stack pointer
                next_mem_addr = sp - 16'h0001;
                next_mem_wdata = (state == ST_PSH) ? pc[15:8] : pc[7:0];
                next_mem_wr = 1'b1;
            end
            ST_TBL:
            begin
                next_mem_addr = tbl_ptr;
                next_mem_rd = 1'b1;
            end
            ST_TBH:
            begin
                next_mem_addr = tbl_ptr + 16'h0001;
                next_mem_rd = 1'b1;
            end
            default:
                next_mem_addr = 16'h0000;
        endcase
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mem_addr <= 16'h0000;
            mem_wdata <= 8'h00;
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            int_ack <= 1'b0;
            busy <= 1'b0;
            irq_enable_out <= 1'b0;
        end
        else
        begin
            mem_addr <= next_mem_addr;
            mem_wdata <= next_mem_wdata;
            mem_rd <= next_mem_rd;
            mem_wr <= next_mem_wr;
            int_ack <= next_int_ack;
            busy <= !idle;
            irq_enable_out <= irq_enable_flag;
        end
    end

    // ================================================================
    // AXI read path
    wire [7:0] ra = {s_axi_araddr[7:2], 2'b00};
    wire rd_go = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `IRU_RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= rd_go;
            if (rd_go)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `IRU_RESP_OKAY;
                case (ra)
                    `IRU_OFF_CTRL: s_axi_rdata <= {21'h000000, !idle, irq_enable_shadow,
                                                   irq_enable_flag, 6'h00, mode};
                    `IRU_OFF_VBASE: s_axi_rdata <= {24'h000000, vbase};
                    `IRU_OFF_PC: s_axi_rdata <= {16'h0000, pc};
                    `IRU_OFF_SP: s_axi_rdata <= {16'h0000, sp};
                    `IRU_OFF_STATUS: s_axi_rdata <= {8'h00, opcode, vec, 4'h0, foreign,
                                                     !idle, cause};
                    default:
                    begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= `IRU_RESP_SLVERR;
                    end
                endcase
            end
            else if (s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

// ===== bench/cir_sva.sv
// Port checker for the interrupt response unit
`timescale 1ns/100ps
module cir_sva
(
    input wire aclk,
    input wire aresetn,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [31:0] s_axi_rdata,
    input wire [15:0] mem_addr,
    input wire mem_rd,
    input wire mem_wr,
    input wire int_ack,
    input wire busy,
    input wire irq_enable_out
);
reg [7:0] ack_run, rd_run, wr_run;
// Strobe run lengths in aclk cycles
always @(posedge aclk)
begin
    ack_run <= (aresetn && int_ack) ? ack_run + 8'h01 : 8'h00;
    rd_run <= (aresetn && mem_rd) ? rd_run + 8'h01 : 8'h00;
    wr_run <= (aresetn && mem_wr) ? wr_run + 8'h01 : 8'h00;
end
default clocking @(posedge aclk); endclocking
default disable iff (!aresetn);
a_ack_len:
    assert property ($fell(int_ack) |-> ack_run == 8'h1C || ack_run == 8'h34)
    else $error("acknowledge length wrong");
a_read_len:
    assert property ($fell(mem_rd) |-> rd_run == 8'h14 || rd_run == 8'h0C || rd_run == 8'h18)
    else $error("read strobe length wrong");
a_push_len:
    assert property ($fell(mem_wr) |-> wr_run == 8'h0C || wr_run == 8'h18)
    else $error("push strobe length wrong");
a_push_order:
    assert property (mem_wr && $past(mem_wr) && mem_addr != $past(mem_addr)
        |-> mem_addr == $past(mem_addr) - 16'h0001) else $error("push address order wrong");
a_accept_clear:
    assert property ($rose(busy) |-> !irq_enable_out) else $error("enable flag not cleared");
a_strobe_busy:
    assert property ($rose(int_ack) || $rose(mem_rd) || $rose(mem_wr) |-> busy)
    else $error("strobe outside response");
a_bresp_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
a_rdata_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule
bind iru_top cir_sva cir_sva_i (.*);

// ===== bench/cir_periph.sv
// Model of the interrupting peripheral and the memory
`timescale 1ns/100ps
module cir_periph
(
    input wire aclk,
    input wire [15:0] mem_addr,
    input wire [7:0] mem_wdata,
    input wire mem_rd,
    input wire mem_wr,
    input wire int_ack,
    input wire [23:0] ack_bytes,
    output reg [7:0] ack_data,
    output wire [7:0] mem_rdata
);
reg [7:0] mem [0:65535];
reg [7:0] run = 8'h00;
reg idle = 1'b0;
wire [4:0] lsb = (run < 8'h1B) ? 5'h00 : (run < 8'h27) ? 5'h08 : 5'h10;
// table bytes by address; released bus toggles
assign mem_rdata = mem_rd ? mem[mem_addr] : {8{idle}};
initial ack_data = 8'h00;
always @(posedge aclk)
begin
    idle <= ~idle;
    run <= int_ack ? run + 8'h01 : 8'h00;
    if (mem_wr)
        mem[mem_addr] <= mem_wdata;
    if (int_ack)
        ack_data <= ack_bytes[lsb +: 8];
    else
        ack_data <= ~ack_data;
end
endmodule

// ===== bench/cpu_interrupt_response_tb.sv
// Self-checking bench for the interrupt response unit
`timescale 1ns/100ps
module cpu_interrupt_response_tb;
reg aclk = 1'b0, aresetn = 1'b0, nmi_n = 1'b1, int_n = 1'b1;
reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
reg [31:0] s_axi_wdata = 32'h0;
reg [3:0] s_axi_wstrb = 4'hF;
reg [23:0] ack_bytes = 24'h0;
reg [15:0] exp_sp = 16'hFFFF, epc;
reg [1:0] md;
reg [41:0] tbl [0:3];
wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
wire mem_rd, mem_wr, int_ack, busy, irq_enable_out;
wire [1:0] s_axi_bresp, s_axi_rresp;
wire [31:0] s_axi_rdata;
wire [15:0] mem_addr;
wire [7:0] ack_data, mem_rdata, mem_wdata;
integer err_total = 0, samples_checked = 0, i, n;
always #2.5 aclk = ~aclk;
iru_top iru_top_i (.*);
cir_periph cir_periph_i
(
    .aclk(aclk), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .int_ack(int_ack), .ack_bytes(ack_bytes),
    .ack_data(ack_data), .mem_rdata(mem_rdata)
);
task chk(input [31:0] seen, input [31:0] exp);
begin
    samples_checked = samples_checked + 1;
    if (seen !== exp)
    begin
        err_total = err_total + 1;
        $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
end
endtask
task end_of_test;
begin
    $display("compares %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
        $display("No errors found");
    else
        $display("Errors were found");
    $finish;
end
endtask
// Each channel drops at its own ready; bready stays up until bvalid
task axi_wr(input [7:0] a, input [31:0] d, input [1:0] r);
begin
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    @(posedge aclk);
    while (s_axi_bvalid !== 1'b1)
    begin
        if (s_axi_awready === 1'b1)
            s_axi_awvalid <= 1'b0;
        if (s_axi_wready === 1'b1)
            s_axi_wvalid <= 1'b0;
        @(posedge aclk);
    end
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h0;
    chk({30'h0, s_axi_bresp}, {30'h0, r});
end
endtask
task axi_rd(input [7:0] a, input [31:0] d, input [1:0] r);
begin
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    @(posedge aclk);
    while (s_axi_rvalid !== 1'b1)
    begin
        if (s_axi_arready === 1'b1)
            s_axi_arvalid <= 1'b0;
        @(posedge aclk);
    end
    {s_axi_arvalid, s_axi_rready} <= 2'h0;
    chk(s_axi_rdata, d);
    chk({30'h0, s_axi_rresp}, {30'h0, r});
end
endtask
// Pins held until the response starts, then released until it ends
task pulse(input nmi, input irq);
begin
    @(posedge aclk);
    {nmi_n, int_n} <= {!nmi, !irq};
    @(posedge aclk);
    while (busy !== 1'b1)
        @(posedge aclk);
    {nmi_n, int_n} <= 2'h3;
    @(posedge aclk);
    while (busy !== 1'b0)
        @(posedge aclk);
end
endtask
task fire(input nmi, input irq, input [15:0] pc_exp);
begin
    axi_wr(8'h08, 32'h4321, 2'h0);
    pulse(nmi, irq);
    axi_rd(8'h08, {16'h0, pc_exp}, 2'h0);
    exp_sp = exp_sp - 16'h0002;
    axi_rd(8'h0C, {16'h0, exp_sp}, 2'h0);
    chk({24'h0, cir_periph_i.mem[exp_sp + 16'h0001]}, 32'h43);
    chk({24'h0, cir_periph_i.mem[exp_sp]}, 32'h21);
end
endtask
// Hang guard, far beyond the expected run
initial
begin
    #150000 err_total = err_total + 1;
    end_of_test;
end
initial
begin
    tbl[0] = {2'h0, 24'h0000D7, 16'h0010};
    tbl[1] = {2'h0, 24'h1234CD, 16'h1234};
    tbl[2] = {2'h1, 24'h0000FF, 16'h0038};
    tbl[3] = {2'h2, 24'h000042, 16'h5678};
    cir_periph_i.mem[16'h8042] = 8'h78;
    cir_periph_i.mem[16'h8043] = 8'h56;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(8'h00, 32'h0, 2'h0);
    axi_rd(8'h04, 32'h0, 2'h0);
    axi_rd(8'h0C, 32'hFFFF, 2'h0);
    axi_rd(8'h14, 32'h0, 2'h2);
    axi_wr(8'h14, 32'h1, 2'h2);
    axi_wr(8'h00, 32'h3, 2'h0);
    axi_rd(8'h00, 32'h0, 2'h0);
    axi_wr(8'h04, 32'h80, 2'h0);
    for (i = 0; i < 4; i = i + 1)
    begin
        {md, ack_bytes, epc} = tbl[i];
        axi_wr(8'h00, 32'h10 | {30'h0, md}, 2'h0);
        fire(1'b0, 1'b1, epc);
        axi_rd(8'h00, {30'h0, md}, 2'h0);
    end
    axi_wr(8'h00, 32'h11, 2'h0);
    fire(1'b1, 1'b1, 16'h0066);
    axi_rd(8'h00, 32'h201, 2'h0);
    axi_wr(8'h00, 32'h41, 2'h0);
    axi_rd(8'h00, 32'h301, 2'h0);
    axi_wr(8'h00, 32'h21, 2'h0);
    axi_rd(8'h00, 32'h1, 2'h0);
    // Unknown mode zero opcode is handed back: no push, foreign flag set
    ack_bytes = 24'h000000;
    axi_wr(8'h00, 32'h10, 2'h0);
    pulse(1'b0, 1'b1);
    axi_rd(8'h08, 32'h66, 2'h0);
    axi_rd(8'h0C, {16'h0, exp_sp}, 2'h0);
    axi_rd(8'h10, 32'h420A, 2'h0);
    axi_wr(8'h10, 32'h8, 2'h0);
    axi_rd(8'h10, 32'h4202, 2'h0);
    int_n <= 1'b0;
    n = 0;
    repeat (80) @(posedge aclk) n = n + (busy !== 1'b0);
    int_n <= 1'b1;
    chk(n, 0);
    end_of_test;
end
endmodule
